// *** awg_pkg.sv ***
/*
  Shared constants, codes, register offsets and carrier types of the arbitrary
  waveform sequencer. Assumes a 100 MHz system clock.
*/
package awg_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int NUM_GEN = 3;
  localparam int NUM_BANKS = 4;
  localparam int BANK_SIZE = 8192;
  localparam int IDX_W = 13;
  localparam int SAMPLE_W = 12;
  localparam int DEG_PER_PERIOD = 720;
  // Counter periods per crank degree, times 100
  localparam int PHASE_FACTOR_X100 = 1138;
  localparam int MAX_RPM = 17578;
  localparam int ONE_MHZ_HZ = 1_000_000;
  localparam logic [6:0] ONE_MHZ_DIV = 7'(CLK_HZ / ONE_MHZ_HZ);
  // Speed clock is rpm * BANK_SIZE / 120 Hz; 32-bit phase accumulator step
  localparam logic [15:0] SPEED_INC_PER_RPM =
    16'(((64'h1 << 32) * BANK_SIZE) / (64'd120 * CLK_HZ));
  // Local clock 48-bit phase accumulator step per hertz
  localparam logic [23:0] LOCAL_INC_PER_HZ = 24'((64'h1 << 48) / CLK_HZ);
  localparam logic [12:0] LAST_IDX = 13'(BANK_SIZE - 1);

  // Global register byte offsets
  localparam logic [7:0] REG_SPEED = 8'h00;
  localparam logic [7:0] REG_ENGINE = 8'h04;
  localparam logic [7:0] REG_STOP_ANGLE = 8'h08;
  localparam logic [7:0] REG_MON_SEL = 8'h0c;
  localparam logic [7:0] REG_CRANK_ANGLE = 8'h10;
  localparam logic [7:0] REG_SEC_OFFSET = 8'h14;
  // Generator g sits at byte 0x40*(g+1); word offsets inside its window
  localparam logic [3:0] GREG_TRIG = 4'h0;
  localparam logic [3:0] GREG_CLK = 4'h1;
  localparam logic [3:0] GREG_MODE = 4'h2;
  localparam logic [3:0] GREG_LFREQ = 4'h3;
  localparam logic [3:0] GREG_CHAN0 = 4'h4;
  localparam logic [3:0] GREG_CHAN1 = 4'h5;
  localparam logic [3:0] GREG_STATIC = 4'h6;
  localparam logic [3:0] GREG_WADDR = 4'h7;
  localparam logic [3:0] GREG_WDATA = 4'h8;
  localparam logic [3:0] GREG_STATUS = 4'h9;

  // Trigger source codes
  localparam logic [3:0] TRIG_SPEED = 4'h0;
  localparam logic [3:0] TRIG_EXT0 = 4'h1;
  localparam logic [3:0] TRIG_EXT3 = 4'h4;
  localparam logic [3:0] TRIG_NONE = 4'ha;
  localparam logic [3:0] TRIG_EXT_OR = 4'hc;
  // Sample clock codes
  localparam logic [2:0] CLK_1MHZ = 3'h0;
  localparam logic [2:0] CLK_LOCAL = 3'h1;
  localparam logic [2:0] CLK_EXT1 = 3'h2;
  localparam logic [2:0] CLK_EXT2 = 3'h3;
  localparam logic [2:0] CLK_SPEED = 3'h4;
  localparam logic [3:0] RST_TRIG_SRC = TRIG_SPEED;
  localparam logic [2:0] RST_CLK_SRC = CLK_SPEED;

  typedef enum logic {GEN_HOLD, GEN_RUN} gen_mode_t;

  typedef struct packed {
    logic [9:0] runtime_phase;
    logic en;
    logic [1:0] bank;
  } chan_cfg_t;

  typedef struct packed {
    logic [3:0] trig_src;
    logic [2:0] clk_src;
    logic [7:0] restart_mode;
    logic [19:0] local_freq;
    chan_cfg_t [1:0] chan;
    logic [1:0][9:0] static_phase;
    logic [14:0] wr_addr;
  } gen_cfg_t;

  typedef struct packed {
    gen_mode_t mode;
    logic [12:0] idx;
    logic [1:0][1:0] active_bank;
  } gen_run_t;

  function automatic logic [12:0] deg_to_idx(input logic [9:0] deg);
    deg_to_idx = 13'((32'(deg) * BANK_SIZE) / DEG_PER_PERIOD);
  endfunction : deg_to_idx

  function automatic logic [9:0] idx_to_deg(input logic [12:0] idx);
    idx_to_deg = 10'((32'(idx) * DEG_PER_PERIOD) / BANK_SIZE);
  endfunction : idx_to_deg
endpackage : awg_pkg

// *** awg_speed_gen.sv ***
/*
  Speed generator: turns the commanded engine speed into a sample clock tick,
  a trigger every bank period, a crank index and two trigger outputs.
  Assumes synchronous inputs on the 100 MHz system clock.
*/
`timescale 1ns/1ps
module awg_speed_gen
  import awg_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Configuration
  input wire logic [14:0] i_target_engine_speed,
  input wire logic i_engine_run_switch,
  input wire logic i_stop_angle_enable,
  input wire logic [9:0] i_stop_crank_angle,
  input wire logic [9:0] i_secondary_trigger_offset,
  // Timing outputs
  output logic o_tick,
  output logic o_trig,
  output logic [12:0] o_idx,
  output logic o_secondary_trigger_out
);
  typedef struct packed {
    logic [31:0] acc;
    logic [12:0] idx;
    logic tick;
    logic trig;
    logic sec;
  } spd_state_t;

  spd_state_t state_ff;
  spd_state_t nxt_state;
  logic moving;
  logic [32:0] sum;

  always_comb begin
    nxt_state = state_ff;
    moving = i_engine_run_switch |
      (i_stop_angle_enable & (state_ff.idx != deg_to_idx(i_stop_crank_angle))); // RQ4
    sum = {1'b0, state_ff.acc} + {2'h0, 31'(32'(i_target_engine_speed) * SPEED_INC_PER_RPM)};
    if (moving) begin
      nxt_state.acc = sum[31:0];
    end
    nxt_state.tick = moving & sum[32];
    nxt_state.trig = moving & sum[32] & (state_ff.idx == LAST_IDX);
    nxt_state.sec = moving & sum[32] &
      (13'(state_ff.idx + 13'h1) == deg_to_idx(i_secondary_trigger_offset));
    if (moving & sum[32]) begin
      nxt_state.idx = 13'(state_ff.idx + 13'h1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_tick = state_ff.tick;
  assign o_trig = state_ff.trig;
  assign o_idx = state_ff.idx;
  assign o_secondary_trigger_out = state_ff.sec;

  property p_stop_now;
    @(posedge i_clk) disable iff (i_rst)
      (!i_engine_run_switch && !i_stop_angle_enable) |=> !o_tick && $stable(o_idx);
  endproperty
  a_stop_now: assert property (p_stop_now) else $error("speed clock runs while off"); // RQ4
endmodule : awg_speed_gen

// *** awg_clock_select.sv ***
/*
  Sample clock selector of one generator: 1 MHz divider, programmable local
  clock, two external clocks and the speed generator tick, as one-cycle ticks.
  Assumes synchronous inputs on the 100 MHz system clock.
*/
`timescale 1ns/1ps
module awg_clock_select
  import awg_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Selection
  input wire logic [2:0] i_sample_clock_select,
  input wire logic [19:0] i_local_clock_frequency,
  // Clock sources
  input wire logic i_speed_tick,
  input wire logic [1:0] i_ext_clk,
  // Selected tick
  output logic o_tick
);
  typedef struct packed {
    logic [6:0] div;
    logic [47:0] acc;
    logic [1:0] ext_prev;
    logic tick;
  } clk_state_t;

  clk_state_t state_ff;
  clk_state_t nxt_state;
  logic [48:0] lsum;
  logic [1:0] ext_rise;

  always_comb begin
    nxt_state = state_ff;
    nxt_state.div = (state_ff.div == 7'(ONE_MHZ_DIV - 7'h1)) ? 7'h0 : 7'(state_ff.div + 7'h1);
    lsum = {1'b0, state_ff.acc} + {5'h0, 44'(44'(i_local_clock_frequency) * LOCAL_INC_PER_HZ)};
    nxt_state.acc = lsum[47:0]; // RQ17
    ext_rise = i_ext_clk & ~state_ff.ext_prev;
    nxt_state.ext_prev = i_ext_clk;
    unique case (i_sample_clock_select) // RQ16 RQ21
      CLK_1MHZ: nxt_state.tick = (state_ff.div == 7'h0);
      CLK_LOCAL: nxt_state.tick = lsum[48];
      CLK_EXT1: nxt_state.tick = ext_rise[0];
      CLK_EXT2: nxt_state.tick = ext_rise[1];
      CLK_SPEED: nxt_state.tick = i_speed_tick;
      default: nxt_state.tick = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_tick = state_ff.tick;

  property p_speed_clk;
    @(posedge i_clk) disable iff (i_rst)
      (i_sample_clock_select == CLK_SPEED) |=> (o_tick == $past(i_speed_tick));
  endproperty
  a_speed_clk: assert property (p_speed_clk) else $error("speed tick not passed"); // RQ21

  property p_local_zero;
    @(posedge i_clk) disable iff (i_rst)
      (i_sample_clock_select == CLK_LOCAL && i_local_clock_frequency == 20'h0
        && state_ff.acc == 48'h0) |=> !o_tick;
  endproperty
  a_local_zero: assert property (p_local_zero) else $error("tick at zero frequency"); // RQ17
endmodule : awg_clock_select

// *** arbitrary_waveform_sequencer.sv ***
/*
  Arbitrary waveform sequencer: generators with four sample banks each, per
  channel bank select, phase and enable, selectable trigger and sample clock,
  speed generator and monitor multiplexer, behind a plain register port.
  Assumes a 100 MHz clock, synchronous inputs and a synchronous reset.
*/
// The address map and the plain strobed port were left to the implementer.
// Summary of operation
// RQ1: Monitor routes one of sixteen sources
// RQ2: Host keeps engine speed within range
// RQ3: Static phase shift per channel applied
// RQ4: Stop at set angle only when enabled
// RQ5: Up to three independent generators
// RQ6: Four sample banks per generator
// RQ7: Each bank holds 8192 samples
// RQ8: Stored sample output on each increment
// RQ9: Bank changes take effect at trigger
// RQ10: Host leaves bank size at 8192
// RQ11: Phase scaled by counts per degree
// RQ12: Channel outputs its selected bank
// RQ13: Channel enable switches output on/off
// RQ14: Phase is static plus runtime offset
// RQ15: Trigger source is selectable
// RQ16: Sample clock source is selectable
// RQ17: Local clock uses frequency setting
// RQ18: Wait mode holds last sample
// RQ19: Continuous mode restarts on trigger/end
// RQ20: Trigger select code decoding
// RQ21: Clock select code decoding
// RQ22: Zero mode continuous, else wait
// RQ23: Host bank selects stay 0-3
// RQ24: Index clears on restart, counts clocks
`timescale 1ns/1ps
module arbitrary_waveform_sequencer
  import awg_pkg::*;
#(
  parameter int N_GEN = NUM_GEN,
  parameter int SAMP_W = SAMPLE_W
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // External triggers, clocks and monitor sources
  input wire logic [3:0] i_ext_trig,
  input wire logic [1:0] i_ext_clk,
  input wire logic [3:0] i_pwm,
  input wire logic [5:0] i_ref_sig,
  // Channel outputs
  output logic [2*N_GEN-1:0][SAMP_W-1:0] o_chan_sample,
  output logic [2*N_GEN-1:0] o_chan_output_enable,
  output logic [SAMP_W-1:0] o_monitor,
  // Speed generator trigger outputs
  output logic o_primary_trigger_out,
  output logic o_secondary_trigger_out
);
  typedef struct packed {
    logic [14:0] speed;
    logic run;
    logic stop_en;
    logic [9:0] stop_angle;
    logic [9:0] sec_offset;
    logic [3:0] mon_sel;
    logic [3:0] ext_prev;
    gen_cfg_t [N_GEN-1:0] cfg;
    gen_run_t [N_GEN-1:0] run_st;
    logic [31:0] rdata;
    logic [SAMP_W-1:0] monitor;
  } awg_state_t;

  awg_state_t state_ff;
  awg_state_t nxt_state;
  logic spd_tick;
  logic spd_trig;
  logic [12:0] spd_idx;
  logic [3:0] ext_rise;
  logic [N_GEN-1:0] trig_w;
  logic [N_GEN-1:0] tick_w;
  logic [15:0][SAMP_W-1:0] mon_src;

  function automatic logic trig_pick(input logic [3:0] sel, input logic spd,
                                     input logic [3:0] ext);
    if (sel == TRIG_SPEED) begin
      trig_pick = spd;
    end else if (sel >= TRIG_EXT0 && sel <= TRIG_EXT3) begin
      trig_pick = ext[2'(sel - TRIG_EXT0)];
    end else if (sel == TRIG_EXT_OR) begin
      trig_pick = |ext;
    end else begin
      trig_pick = 1'b0;
    end
  endfunction : trig_pick

  awg_speed_gen u_speed (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_target_engine_speed(state_ff.speed),
    .i_engine_run_switch(state_ff.run),
    .i_stop_angle_enable(state_ff.stop_en),
    .i_stop_crank_angle(state_ff.stop_angle),
    .i_secondary_trigger_offset(state_ff.sec_offset),
    .o_tick(spd_tick),
    .o_trig(spd_trig),
    .o_idx(spd_idx),
    .o_secondary_trigger_out(o_secondary_trigger_out)
  );
  assign o_primary_trigger_out = spd_trig;
  assign ext_rise = i_ext_trig & ~state_ff.ext_prev;

  for (genvar g = 0; g < N_GEN; g++) begin : g_gen // RQ5
    logic [SAMP_W-1:0] mem [NUM_BANKS*BANK_SIZE]; // RQ6 RQ7
    logic [1:0][SAMP_W-1:0] samp_ff;
    logic [1:0][12:0] pos;

    awg_clock_select u_clk (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_sample_clock_select(state_ff.cfg[g].clk_src),
      .i_local_clock_frequency(state_ff.cfg[g].local_freq),
      .i_speed_tick(spd_tick),
      .i_ext_clk(i_ext_clk),
      .o_tick(tick_w[g])
    );
    assign trig_w[g] = trig_pick(state_ff.cfg[g].trig_src, spd_trig, ext_rise); // RQ15 RQ20

    for (genvar c = 0; c < 2; c++) begin : g_chan
      // Sample position plus static and runtime phase, wrapping at bank end
      assign pos[c] = 13'(state_ff.run_st[g].idx + deg_to_idx(state_ff.cfg[g].static_phase[c])
        + deg_to_idx(state_ff.cfg[g].chan[c].runtime_phase)); // RQ3 RQ11 RQ14
      assign o_chan_sample[2*g+c] = samp_ff[c];
      assign o_chan_output_enable[2*g+c] = state_ff.cfg[g].chan[c].en;
    end

    always_ff @(posedge i_clk) begin
      if (i_wr && i_addr == {2'(g + 1), GREG_WDATA, 2'h0}) begin
        mem[state_ff.cfg[g].wr_addr] <= i_wdata[SAMP_W-1:0];
      end
      for (int c = 0; c < 2; c++) begin
        if (i_rst || !state_ff.cfg[g].chan[c].en) begin
          samp_ff[c] <= '0; // RQ13
        end else begin
          samp_ff[c] <= mem[{state_ff.run_st[g].active_bank[c], pos[c]}]; // RQ8 RQ12
        end
      end
    end

    property p_restart;
      @(posedge i_clk) disable iff (i_rst)
        trig_w[g] |=> state_ff.run_st[g].idx == 13'h0 && state_ff.run_st[g].mode == GEN_RUN;
    endproperty
    a_restart: assert property (p_restart) else $error("trigger did not restart"); // RQ24

    property p_advance;
      @(posedge i_clk) disable iff (i_rst)
        (tick_w[g] && !trig_w[g] && state_ff.run_st[g].mode == GEN_RUN
          && state_ff.run_st[g].idx != LAST_IDX)
        |=> state_ff.run_st[g].idx == 13'($past(state_ff.run_st[g].idx) + 13'h1);
    endproperty
    a_advance: assert property (p_advance) else $error("index did not advance"); // RQ24

    property p_wait_hold;
      @(posedge i_clk) disable iff (i_rst)
        (tick_w[g] && !trig_w[g] && state_ff.run_st[g].idx == LAST_IDX
          && state_ff.cfg[g].restart_mode != 8'h0)
        |=> state_ff.run_st[g].mode == GEN_HOLD && state_ff.run_st[g].idx == LAST_IDX;
    endproperty
    a_wait_hold: assert property (p_wait_hold) else $error("wait mode did not hold"); // RQ18

    property p_cont_wrap;
      @(posedge i_clk) disable iff (i_rst)
        (tick_w[g] && !trig_w[g] && state_ff.run_st[g].idx == LAST_IDX
          && state_ff.cfg[g].restart_mode == 8'h0) |=> state_ff.run_st[g].idx == 13'h0;
    endproperty
    a_cont_wrap: assert property (p_cont_wrap) else $error("continuous did not wrap"); // RQ19

    property p_bank_hold;
      @(posedge i_clk) disable iff (i_rst)
        !trig_w[g] |=> $stable(state_ff.run_st[g].active_bank);
    endproperty
    a_bank_hold: assert property (p_bank_hold) else $error("bank changed off trigger"); // RQ9

    property p_bank_take;
      @(posedge i_clk) disable iff (i_rst)
        trig_w[g] |=> state_ff.run_st[g].active_bank[0] == $past(state_ff.cfg[g].chan[0].bank);
    endproperty
    a_bank_take: assert property (p_bank_take) else $error("bank not taken at trigger"); // RQ9

    property p_disabled;
      @(posedge i_clk) disable iff (i_rst)
        !state_ff.cfg[g].chan[0].en |=> samp_ff[0] == '0;
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled channel drives"); // RQ13

    property p_no_trig;
      @(posedge i_clk) disable iff (i_rst)
        (state_ff.cfg[g].trig_src == TRIG_NONE) |-> !trig_w[g];
    endproperty
    a_no_trig: assert property (p_no_trig) else $error("trigger with no source"); // RQ20

    property p_speed_trig;
      @(posedge i_clk) disable iff (i_rst)
        (state_ff.cfg[g].trig_src == TRIG_SPEED && spd_trig) |-> trig_w[g];
    endproperty
    a_speed_trig: assert property (p_speed_trig) else $error("speed trigger lost"); // RQ15
  end

  // Monitor sources: channel samples, PWM levels, reference levels
  for (genvar k = 0; k < 6; k++) begin : g_mon
    if (k < 2 * N_GEN) begin : g_have
      assign mon_src[k] = o_chan_sample[k];
    end else begin : g_none
      assign mon_src[k] = '0;
    end
    assign mon_src[10+k] = {SAMP_W{i_ref_sig[k]}};
    if (k < 4) begin : g_pwm
      assign mon_src[6+k] = {SAMP_W{i_pwm[k]}};
    end
  end

  always_comb begin
    logic hit;
    hit = 1'b0;
    nxt_state = state_ff;
    nxt_state.rdata = '0;
    nxt_state.ext_prev = i_ext_trig;
    nxt_state.monitor = mon_src[state_ff.mon_sel]; // RQ1
    if (i_wr) begin
      case (i_addr)
        REG_SPEED: nxt_state.speed = i_wdata[14:0];
        REG_ENGINE: begin
          nxt_state.run = i_wdata[0];
          nxt_state.stop_en = i_wdata[1];
        end
        REG_STOP_ANGLE: nxt_state.stop_angle = i_wdata[9:0];
        REG_MON_SEL: nxt_state.mon_sel = i_wdata[3:0];
        REG_SEC_OFFSET: nxt_state.sec_offset = i_wdata[9:0];
        default: ;
      endcase
    end
    if (i_rd) begin
      case (i_addr)
        REG_SPEED: nxt_state.rdata = {17'h0, state_ff.speed};
        REG_ENGINE: nxt_state.rdata = {30'h0, state_ff.stop_en, state_ff.run};
        REG_STOP_ANGLE: nxt_state.rdata = {22'h0, state_ff.stop_angle};
        REG_MON_SEL: nxt_state.rdata = {28'h0, state_ff.mon_sel};
        REG_CRANK_ANGLE: nxt_state.rdata = {22'h0, idx_to_deg(spd_idx)};
        REG_SEC_OFFSET: nxt_state.rdata = {22'h0, state_ff.sec_offset};
        default: ;
      endcase
    end
    for (int g = 0; g < N_GEN; g++) begin
      hit = (i_addr[7:6] == 2'(g + 1)) && (i_addr[1:0] == 2'h0);
      if (i_wr && hit) begin
        case (i_addr[5:2])
          GREG_TRIG: nxt_state.cfg[g].trig_src = i_wdata[3:0];
          GREG_CLK: nxt_state.cfg[g].clk_src = i_wdata[2:0];
          GREG_MODE: nxt_state.cfg[g].restart_mode = i_wdata[7:0];
          GREG_LFREQ: nxt_state.cfg[g].local_freq = i_wdata[19:0];
          GREG_CHAN0: nxt_state.cfg[g].chan[0] = {i_wdata[25:16], i_wdata[2], i_wdata[1:0]};
          GREG_CHAN1: nxt_state.cfg[g].chan[1] = {i_wdata[25:16], i_wdata[2], i_wdata[1:0]};
          GREG_STATIC: nxt_state.cfg[g].static_phase = {i_wdata[25:16], i_wdata[9:0]};
          GREG_WADDR: nxt_state.cfg[g].wr_addr = i_wdata[14:0];
          GREG_WDATA: nxt_state.cfg[g].wr_addr = 15'(state_ff.cfg[g].wr_addr + 15'h1);
          default: ;
        endcase
      end
      if (i_rd && hit) begin
        case (i_addr[5:2])
          GREG_TRIG: nxt_state.rdata = {28'h0, state_ff.cfg[g].trig_src};
          GREG_CLK: nxt_state.rdata = {29'h0, state_ff.cfg[g].clk_src};
          GREG_MODE: nxt_state.rdata = {24'h0, state_ff.cfg[g].restart_mode};
          GREG_LFREQ: nxt_state.rdata = {12'h0, state_ff.cfg[g].local_freq};
          GREG_CHAN0: nxt_state.rdata = {6'h0, state_ff.cfg[g].chan[0].runtime_phase, 13'h0,
            state_ff.cfg[g].chan[0].en, state_ff.cfg[g].chan[0].bank};
          GREG_CHAN1: nxt_state.rdata = {6'h0, state_ff.cfg[g].chan[1].runtime_phase, 13'h0,
            state_ff.cfg[g].chan[1].en, state_ff.cfg[g].chan[1].bank};
          GREG_STATIC: nxt_state.rdata = {6'h0, state_ff.cfg[g].static_phase[1], 6'h0,
            state_ff.cfg[g].static_phase[0]};
          GREG_WADDR: nxt_state.rdata = {17'h0, state_ff.cfg[g].wr_addr};
          GREG_STATUS: nxt_state.rdata = {14'h0, state_ff.run_st[g].mode == GEN_RUN,
            state_ff.run_st[g].active_bank, state_ff.run_st[g].idx};
          default: ;
        endcase
      end
      // Sequencing: trigger restarts and loads pending banks
      if (trig_w[g]) begin
        nxt_state.run_st[g].mode = GEN_RUN; // RQ19
        nxt_state.run_st[g].idx = 13'h0; // RQ24
        nxt_state.run_st[g].active_bank[0] = state_ff.cfg[g].chan[0].bank; // RQ9
        nxt_state.run_st[g].active_bank[1] = state_ff.cfg[g].chan[1].bank; // RQ9
      end else if (tick_w[g] && (state_ff.run_st[g].mode == GEN_RUN
                   || state_ff.cfg[g].restart_mode == 8'h0)) begin
        nxt_state.run_st[g].mode = GEN_RUN;
        if (state_ff.run_st[g].idx != LAST_IDX) begin
          nxt_state.run_st[g].idx = 13'(state_ff.run_st[g].idx + 13'h1); // RQ24
        end else if (state_ff.cfg[g].restart_mode == 8'h0) begin
          nxt_state.run_st[g].idx = 13'h0; // RQ19 RQ22
        end else begin
          nxt_state.run_st[g].mode = GEN_HOLD; // RQ18 RQ22
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_ff <= '0;
      for (int g = 0; g < N_GEN; g++) begin
        state_ff.cfg[g].trig_src <= RST_TRIG_SRC;
        state_ff.cfg[g].clk_src <= RST_CLK_SRC;
      end
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_rdata = state_ff.rdata;
  assign o_monitor = state_ff.monitor;

  property p_mon_pwm;
    @(posedge i_clk) disable iff (i_rst)
      (state_ff.mon_sel == 4'h6 && i_pwm[0]) |=> o_monitor == {SAMP_W{1'b1}};
  endproperty
  a_mon_pwm: assert property (p_mon_pwm) else $error("monitor missed PWM source"); // RQ1

  property p_mon_ref;
    @(posedge i_clk) disable iff (i_rst)
      (state_ff.mon_sel == 4'hf && !i_ref_sig[5]) |=> o_monitor == '0;
  endproperty
  a_mon_ref: assert property (p_mon_ref) else $error("monitor missed reference"); // RQ1
endmodule : arbitrary_waveform_sequencer

// *** awg_host.sv ***
/*
  Host model: writes and reads the register port of the sequencer.
  Assumes the bench clock and a released reset before the first access.
*/
`timescale 1ns/1ps
module awg_host (
  // Clock and read data
  input wire logic i_clk,
  input wire logic [31:0] i_rdata,
  // Register port
  output logic [7:0] o_addr,
  output logic [31:0] o_wdata,
  output logic o_wr,
  output logic o_rd
);
  initial begin
    o_addr = 8'h00;
    o_wdata = 32'h0;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= dat;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] dat);
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    #1;
    dat = i_rdata;
  endtask : rd
endmodule : awg_host

// *** arbitrary_waveform_sequencer_tb.sv ***
/*
  Bench of the sequencer: monitor routing, banks, phase, enable, trigger
  and restart modes of generator 0, sample clocks and the speed generator.
  Assumes the awg_host register model.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
  end \
end
module arbitrary_waveform_sequencer_tb;
  logic i_clk;
  logic i_rst;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic [3:0] ext_trig;
  logic [1:0] ext_clk;
  logic [3:0] pwm;
  logic [5:0] ref_sig;
  logic [5:0][11:0] samp;
  logic [5:0] oen;
  logic [11:0] mon;
  logic [31:0] d;
  logic [31:0] e;
  logic ptrig;
  logic strig;
  int n_mismatch = 0;
  int comparisons = 0;
  int n_ptrig = 0;
  int n_strig = 0;
  awg_host awg_host_inst (.i_clk(i_clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
    .o_wr(wr), .o_rd(rd));
  arbitrary_waveform_sequencer arbitrary_waveform_sequencer_inst (.i_clk(i_clk),
    .i_rst(i_rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_ext_trig(ext_trig), .i_ext_clk(ext_clk), .i_pwm(pwm), .i_ref_sig(ref_sig),
    .o_chan_sample(samp), .o_chan_output_enable(oen), .o_monitor(mon),
    .o_primary_trigger_out(ptrig), .o_secondary_trigger_out(strig));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // Count speed generator trigger pulses
  always @(posedge i_clk) begin
    if (ptrig === 1'b1) n_ptrig <= n_ptrig + 1;
    if (strig === 1'b1) n_strig <= n_strig + 1;
  end
  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test
  task automatic settle;
    repeat (4) @(posedge i_clk);
    #1;
  endtask : settle
  task automatic trig(input logic [3:0] m);
    @(posedge i_clk);
    ext_trig <= m;
    @(posedge i_clk);
    ext_trig <= 4'h0;
    settle();
  endtask : trig
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge i_clk);
      ext_clk <= 2'b01;
      @(posedge i_clk);
      ext_clk <= 2'b00;
    end
    settle();
  endtask : ticks
  task automatic load(input logic [14:0] wa, input logic [11:0] base);
    awg_host_inst.wr(8'h5c, {17'h0, wa});
    for (int k = 0; k < 4; k++) awg_host_inst.wr(8'h60, {20'h0, base + 12'(k)});
  endtask : load
  initial begin
    #1_000_000;
    n_mismatch++;
    stop_test();
  end
  initial begin
    i_rst = 1'b1;
    ext_trig = 4'h0;
    ext_clk = 2'b00;
    pwm = 4'h5;
    ref_sig = 6'h26;
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    settle();
    awg_host_inst.rd(8'h3c, d);
    `CHK("unmapped read", 32'h0, d)
    for (int k = 6; k < 16; k++) begin
      awg_host_inst.wr(8'h0c, 32'(k));
      settle();
      `CHK("monitor", {12{k < 10 ? pwm[k-6] : ref_sig[k-10]}}, mon)
    end
    awg_host_inst.wr(8'h40, 32'h1);
    awg_host_inst.wr(8'h44, 32'h2);
    awg_host_inst.wr(8'h48, 32'h1);
    awg_host_inst.wr(8'h58, 32'h1_0000);
    awg_host_inst.wr(8'h50, 32'h4);
    awg_host_inst.wr(8'h54, 32'h1_0005);
    awg_host_inst.wr(8'h0c, 32'h0);
    load(15'h0000, 12'h100);
    load(15'h1ffc, 12'h1f0);
    load(15'h2016, 12'h300);
    load(15'h4000, 12'h200);
    trig(4'h1);
    `CHK("ch0 first", 12'h100, samp[0])
    `CHK("ch1 phase", 12'h300, samp[1])
    `CHK("enables", 2'b11, oen[1:0])
    `CHK("monitor ch0", 12'h100, mon)
    ticks(1);
    `CHK("ch0 step", 12'h101, samp[0])
    `CHK("ch1 step", 12'h301, samp[1])
    ticks(8200);
    `CHK("wait hold", 12'h1f3, samp[0])
    awg_host_inst.rd(8'h64, d);
    `CHK("hold index", 13'h1fff, d[12:0])
    awg_host_inst.wr(8'h50, 32'h6);
    settle();
    `CHK("bank pending", 12'h1f3, samp[0])
    trig(4'h1);
    `CHK("bank switched", 12'h200, samp[0])
    awg_host_inst.wr(8'h48, 32'h0);
    ticks(8193);
    `CHK("wrap sample", 12'h201, samp[0])
    awg_host_inst.rd(8'h64, d);
    `CHK("wrap index", 13'h0001, d[12:0])
    awg_host_inst.wr(8'h50, 32'h2);
    settle();
    `CHK("disabled en", 1'b0, oen[0])
    `CHK("disabled out", 12'h000, samp[0])
    awg_host_inst.wr(8'h40, 32'ha);
    trig(4'h1);
    awg_host_inst.rd(8'h64, d);
    `CHK("no trigger", 13'h0001, d[12:0])
    awg_host_inst.wr(8'h40, 32'hc);
    trig(4'h8);
    awg_host_inst.rd(8'h64, d);
    `CHK("trigger or", 13'h0000, d[12:0])
    // Generator 2 on the 1 MHz clock: ten ticks in 1000 cycles
    awg_host_inst.wr(8'hc4, 32'h0);
    repeat (1000) @(posedge i_clk);
    awg_host_inst.rd(8'he4, d);
    `CHK("1 MHz ticks", 13'd10, d[12:0])
    // Generator 1 counts speed ticks; 1 degree is index 11
    awg_host_inst.wr(8'h14, 32'h1);
    awg_host_inst.wr(8'h08, 32'h1);
    awg_host_inst.wr(8'h00, 32'd17578);
    awg_host_inst.wr(8'h04, 32'h2);
    repeat (1500) @(posedge i_clk);
    awg_host_inst.rd(8'ha4, d);
    `CHK("stop angle index", 13'd11, d[12:0])
    `CHK("secondary pulses", 1, n_strig)
    awg_host_inst.wr(8'h04, 32'h1);
    repeat (400) @(posedge i_clk);
    awg_host_inst.wr(8'h04, 32'h0);
    settle();
    awg_host_inst.rd(8'ha4, d);
    repeat (400) @(posedge i_clk);
    awg_host_inst.rd(8'ha4, e);
    `CHK("engine ran", 1'b1, d[12:0] > 13'd11)
    `CHK("stopped at once", d[12:0], e[12:0])
    `CHK("primary pulses", 0, n_ptrig)
    stop_test();
  end
endmodule : arbitrary_waveform_sequencer_tb
